// [rtl/pdwd_watchdog.sv]
`timescale 1ns/1ps
// Summary of operation
// - Reset leaves watchdog enabled at 500 ms
// - First output write arms and starts count
// - Each output write restarts count from zero
// - Reads never arm or restart the watchdog
// - Expiry applies fault response, sets failure flag
// - Failure stores its reason code
// - Armed watchdog cannot be stopped by client
// - Output writes blocked until failure acknowledged
// - Acknowledge restarts the watchdog count
// - Timeout programmable 200 to 65000 ms
// - Zero timeout disables only while unarmed
// - Command 0002 acknowledges and clears failure
// - Reason code readable at 2004
// - Reason codes 000C, 000D, 0009
// - Up to eight connections served
// - Static access aborts driver link until reset
// - Table writes serialized by a lock
// - Requests accepted on TCP port 502
// - Function codes 3, 4, 6, 16, 23
// - Dynamic table layout from 8000, inputs read-only
// - Static table four regions, inputs read-only
// - Diagnostic words 7996 to 7999 read-only
// - Fault mode 0, 1 or 2
// - Status bit 1 shows failure present
module pdwd_watchdog #(
    parameter int TICK = pdwd_pkg::TICK_CYCLES,
    parameter int BUS_IN = 4,
    parameter int BUS_OUT = 4
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Modbus request engine
    input wire logic [7:0] req_valid_in,
    input pdwd_pkg::pdwd_req_t req_in [8],
    output logic [7:0] req_ready_out,
    output pdwd_pkg::pdwd_resp_t resp_out,
    input wire logic conn_timeout_in,
    output logic [15:0] conn_tmo_ms_out,
    output logic [15:0] tcp_port_out,
    // Driver interface link
    input wire logic drv_active_in,
    output logic drv_abort_out,
    output logic [15:0] drv_abort_code_out,
    // Local bus process image
    output logic [9:0] img_rd_addr_out,
    input wire logic [15:0] img_rd_data_in,
    output pdwd_pkg::pdwd_img_wr_t img_wr_out,
    input wire logic [15:0] diag_status_in,
    input wire logic [15:0] diag_param1_in,
    input wire logic [15:0] diag_param2_in,
    // Fault response
    output logic net_fail_out,
    output logic net_fail_led_out,
    output logic fault_apply_out,
    output logic [1:0] fault_mode_out
);
    import pdwd_pkg::*;

    pdwd_state_t state;
    logic [15:0] wd_tmo;
    logic [15:0] conn_tmo;
    logic [1:0] mode;
    logic [15:0] reason;
    logic drv_abort;
    logic [15:0] tick_cnt;
    logic [15:0] ms_cnt;
    logic [2:0] rr_ptr;
    logic [2:0] lock_own;
    logic lock_held;
    logic [2:0] pick;
    logic take;
    pdwd_req_t cur;
    logic hit;
    logic wable;
    logic is_out;
    logic is_img;
    logic [9:0] img_idx;
    logic [15:0] off;
    logic fc_ok;
    logic [7:0] exc;
    logic [15:0] rdata;
    logic do_wr;
    logic trigger;
    logic tick;
    logic expire;
    logic ack;
    logic force_fail;
    logic fail_event;

    // Lock owner keeps the grant until its last word, so multi-word writes never interleave
    always_comb
    begin
        logic [2:0] idx;
        idx = 3'h0;
        pick = 3'h0;
        take = 1'b0;
        if (lock_held)
        begin
            pick = lock_own;
            take = req_valid_in[lock_own];
        end
        else
        begin
            for (int k = 0; k < NCONN; k++)
            begin
                idx = rr_ptr + 3'(k);
                if (!take && req_valid_in[idx])
                begin
                    pick = idx;
                    take = 1'b1;
                end
            end
        end
        req_ready_out = 8'h00;
        req_ready_out[pick] = take;
        cur = req_in[pick];
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            lock_held <= 1'b0;
            lock_own <= 3'h0;
            rr_ptr <= 3'h0;
        end
        else if (take)
        begin
            lock_held <= cur.write && !cur.last;
            lock_own <= pick;
            if (!lock_held)
            begin
                rr_ptr <= pick + 3'h1;
            end
        end
    end

    // Address decode
    always_comb
    begin
        hit = 1'b0;
        wable = 1'b0;
        is_out = 1'b0;
        is_img = 1'b0;
        img_idx = 10'h000;
        off = cur.addr - A_DYN;
        if (cur.addr < A_STAT_END)
        begin
            hit = 1'b1;
            is_img = 1'b1;
            img_idx = cur.addr[9:0];
            wable = cur.addr >= A_DO;
            is_out = cur.addr >= A_DO;
        end
        else if (cur.addr >= A_DYN)
        begin
            if (off == 16'h0000)
            begin
                hit = 1'b1;
                is_img = 1'b1;
                img_idx = IMG_LOC_IN;
            end
            else if (off <= 16'(BUS_IN))
            begin
                hit = 1'b1;
                is_img = 1'b1;
                img_idx = A_DI[9:0] + 10'(off - 16'h0001);
            end
            else if (off == 16'(BUS_IN + 1))
            begin
                hit = 1'b1;
                is_img = 1'b1;
                wable = 1'b1;
                is_out = 1'b1;
                img_idx = IMG_LOC_OUT;
            end
            else if (off <= 16'(BUS_IN + 1 + BUS_OUT))
            begin
                hit = 1'b1;
                is_img = 1'b1;
                wable = 1'b1;
                is_out = 1'b1;
                img_idx = A_DO[9:0] + 10'(off - 16'(BUS_IN + 2));
            end
        end
        else
        begin
            case (cur.addr)
                A_CONN_TMO, A_WD_TMO, A_MODE, A_REASON, A_CMD:
                begin
                    hit = 1'b1;
                    wable = 1'b1;
                end
                A_STATUS, A_DIAG_ST, A_DIAG_P1, A_DIAG_P2:
                begin
                    hit = 1'b1;
                end
                default:
                begin
                    hit = 1'b0;
                end
            endcase
        end
    end

    // Exception priority: function, address, value, then blocked outputs
    always_comb
    begin
        fc_ok = cur.write ? (cur.fc == FC_WR_ONE || cur.fc == FC_WR_MULTI || cur.fc == FC_RDWR)
                          : (cur.fc == FC_RD_HOLD || cur.fc == FC_RD_IN || cur.fc == FC_RDWR);
        exc = EXC_NONE;
        if (!fc_ok)
        begin
            exc = EXC_FUNC;
        end
        else if (!hit || (cur.write && !wable))
        begin
            exc = EXC_ADDR;
        end
        else if (cur.write && cur.addr == A_WD_TMO && cur.wdata == 16'h0000 && state != WD_INIT)
        begin
            exc = EXC_VALUE;
        end
        else if (cur.write && (cur.addr == A_WD_TMO || cur.addr == A_CONN_TMO) && cur.wdata != 16'h0000
                 && (cur.wdata < TMO_MIN || cur.wdata > TMO_MAX))
        begin
            exc = EXC_VALUE;
        end
        else if (cur.write && cur.addr == A_MODE && cur.wdata > 16'(MODE_HOLD))
        begin
            exc = EXC_VALUE;
        end
        else if (cur.write && is_out && state == WD_FAILED)
        begin
            exc = EXC_FAIL;
        end
    end

    assign do_wr = take && cur.write && exc == EXC_NONE;
    assign trigger = do_wr && is_out;
    assign ack = do_wr && cur.addr == A_CMD && cur.wdata == CMD_ACK;
    assign force_fail = do_wr && cur.addr == A_CMD && cur.wdata == CMD_FORCE;
    assign img_rd_addr_out = img_idx;

    // Read data
    always_comb
    begin
        rdata = 16'h0000;
        if (is_img)
        begin
            rdata = img_rd_data_in;
        end
        else
        begin
            case (cur.addr)
                A_CONN_TMO: rdata = conn_tmo;
                A_WD_TMO: rdata = wd_tmo;
                A_MODE: rdata = {14'h0000, mode};
                A_REASON: rdata = reason;
                A_STATUS:
                begin
                    rdata[ST_OK_BIT] = (diag_status_in[4:0] & DIAG_ERR_MASK) == 5'h00;
                    rdata[ST_FAIL_BIT] = state == WD_FAILED;
                end
                A_DIAG_ST: rdata = diag_status_in;
                A_DIAG_P1: rdata = diag_param1_in;
                A_DIAG_P2: rdata = diag_param2_in;
                default: rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            resp_out <= '0;
            img_wr_out <= '0;
        end
        else
        begin
            resp_out.valid <= take;
            resp_out.conn <= pick;
            resp_out.exc <= exc;
            resp_out.rdata <= rdata;
            img_wr_out.valid <= do_wr && is_img;
            img_wr_out.addr <= img_idx;
            img_wr_out.data <= cur.wdata;
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            wd_tmo <= WD_TMO_RST;
            conn_tmo <= CONN_TMO_RST;
            mode <= MODE_RESET;
        end
        else if (do_wr)
        begin
            if (cur.addr == A_WD_TMO)
            begin
                wd_tmo <= cur.wdata;
            end
            if (cur.addr == A_CONN_TMO)
            begin
                conn_tmo <= cur.wdata;
            end
            if (cur.addr == A_MODE)
            begin
                mode <= cur.wdata[1:0];
            end
        end
    end

    // Millisecond time base; it restarts with the count so a trigger gives a full period
    assign tick = tick_cnt == 16'(TICK - 1);
    assign expire = state == WD_ARMED && tick && 17'(ms_cnt) + 17'h00001 >= 17'(wd_tmo) && !trigger;

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in || state != WD_ARMED || trigger)
        begin
            tick_cnt <= 16'h0000;
            ms_cnt <= 16'h0000;
        end
        else if (tick)
        begin
            tick_cnt <= 16'h0000;
            ms_cnt <= ms_cnt + 16'h0001;
        end
        else
        begin
            tick_cnt <= tick_cnt + 16'h0001;
        end
    end

    assign fail_event = expire || conn_timeout_in || force_fail;

    // Watchdog states; a new failure wins over an acknowledge in the same cycle
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            state <= WD_INIT;
        end
        else if (fail_event)
        begin
            state <= WD_FAILED;
        end
        else
        begin
            case (state)
                WD_INIT:
                begin
                    if (do_wr && cur.addr == A_WD_TMO && cur.wdata == 16'h0000)
                    begin
                        state <= WD_OFF;
                    end
                    else if (trigger && wd_tmo != 16'h0000)
                    begin
                        state <= WD_ARMED;
                    end
                end
                WD_FAILED:
                begin
                    if (ack)
                    begin
                        state <= wd_tmo == 16'h0000 ? WD_OFF : WD_ARMED;
                    end
                end
                default:
                begin
                    state <= state;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            reason <= REASON_NONE;
            fault_apply_out <= 1'b0;
        end
        else
        begin
            fault_apply_out <= fail_event && state != WD_FAILED;
            if (expire)
            begin
                reason <= REASON_WD;
            end
            else if (conn_timeout_in)
            begin
                reason <= REASON_CONN;
            end
            else if (force_fail)
            begin
                reason <= REASON_USER;
            end
            else if (do_wr && cur.addr == A_REASON)
            begin
                reason <= cur.wdata;
            end
        end
    end

    // The driver link stays refused once aborted; only reset brings it back
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            drv_abort <= 1'b0;
        end
        else if (take && drv_active_in && cur.addr < A_STAT_END)
        begin
            drv_abort <= 1'b1;
        end
    end

    assign net_fail_out = state == WD_FAILED;
    assign net_fail_led_out = state == WD_FAILED;
    assign fault_mode_out = mode;
    assign conn_tmo_ms_out = conn_tmo;
    assign tcp_port_out = TCP_PORT;
    assign drv_abort_out = drv_abort;
    assign drv_abort_code_out = drv_abort ? DRV_ABORT_CODE : 16'h0000;

    sequence s_expire;
        state == WD_ARMED ##0 expire;
    endsequence

    sequence s_ack_ok;
        state == WD_FAILED && ack && !fail_event && wd_tmo != 16'h0000;
    endsequence

    property p_rst_tmo;
        @(posedge core_clk_in) disable iff (rst_in) $fell(rst_in) |-> wd_tmo == WD_TMO_RST && state == WD_INIT;
    endproperty
    a_rst_tmo: assert property (p_rst_tmo) else $error("timeout not default after reset");

    property p_arm;
        @(posedge core_clk_in) disable iff (rst_in)
            state == WD_INIT && trigger && wd_tmo != 16'h0000 && !fail_event |=> state == WD_ARMED;
    endproperty
    a_arm: assert property (p_arm) else $error("first write did not arm");

    property p_restart;
        @(posedge core_clk_in) disable iff (rst_in) state == WD_ARMED && trigger |=> ms_cnt == 16'h0000;
    endproperty
    a_restart: assert property (p_restart) else $error("trigger did not restart count");

    property p_read;
        @(posedge core_clk_in) disable iff (rst_in)
            state == WD_ARMED && take && !cur.write && !tick |=> ms_cnt == $past(ms_cnt);
    endproperty
    a_read: assert property (p_read) else $error("read triggered watchdog");

    property p_expire;
        @(posedge core_clk_in) disable iff (rst_in) s_expire |=> net_fail_out && fault_apply_out && reason == REASON_WD;
    endproperty
    a_expire: assert property (p_expire) else $error("expiry response missing");

    property p_conn_reason;
        @(posedge core_clk_in) disable iff (rst_in) conn_timeout_in && !expire |=> reason == REASON_CONN;
    endproperty
    a_conn_reason: assert property (p_conn_reason) else $error("reason not stored");

    property p_no_stop;
        @(posedge core_clk_in) disable iff (rst_in) state == WD_ARMED |=> state == WD_ARMED || state == WD_FAILED;
    endproperty
    a_no_stop: assert property (p_no_stop) else $error("armed watchdog stopped");

    property p_blocked;
        @(posedge core_clk_in) disable iff (rst_in)
            state == WD_FAILED && take && cur.write && is_out |=> resp_out.exc == EXC_FAIL && !img_wr_out.valid;
    endproperty
    a_blocked: assert property (p_blocked) else $error("output write passed during failure");

    property p_ack;
        @(posedge core_clk_in) disable iff (rst_in) s_ack_ok |=> state == WD_ARMED && ms_cnt == 16'h0000 && !net_fail_out;
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge did not restart");

    property p_range;
        @(posedge core_clk_in) disable iff (rst_in)
            take && cur.write && cur.addr == A_WD_TMO && cur.wdata != 16'h0000 && cur.wdata < TMO_MIN
            |=> wd_tmo == $past(wd_tmo) && resp_out.exc != EXC_NONE;
    endproperty
    a_range: assert property (p_range) else $error("short timeout accepted");

    property p_lock;
        @(posedge core_clk_in) disable iff (rst_in) lock_held && take |-> pick == lock_own;
    endproperty
    a_lock: assert property (p_lock) else $error("lock owner bypassed");
endmodule

// [rtl/pdwd_pkg.sv]
package pdwd_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS = 1000000;
    localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int NCONN = 8;
    // Register offsets
    localparam logic [15:0] A_DI = 16'h0000;
    localparam logic [15:0] A_AI = 16'h00c0;
    localparam logic [15:0] A_DO = 16'h0180;
    localparam logic [15:0] A_AO = 16'h0240;
    localparam logic [15:0] A_STAT_END = 16'h0300;
    localparam logic [15:0] A_CONN_TMO = 16'h0500;
    localparam logic [15:0] A_WD_TMO = 16'h07d0;
    localparam logic [15:0] A_MODE = 16'h07d2;
    localparam logic [15:0] A_REASON = 16'h07d4;
    localparam logic [15:0] A_CMD = 16'h07d6;
    localparam logic [15:0] A_STATUS = 16'h1f3c;
    localparam logic [15:0] A_DIAG_ST = 16'h1f3d;
    localparam logic [15:0] A_DIAG_P1 = 16'h1f3e;
    localparam logic [15:0] A_DIAG_P2 = 16'h1f3f;
    localparam logic [15:0] A_DYN = 16'h1f40;
    // Image indices for the two local words
    localparam logic [9:0] IMG_LOC_IN = 10'h300;
    localparam logic [9:0] IMG_LOC_OUT = 10'h301;
    // Values and reset values
    localparam logic [15:0] TMO_MIN = 16'h00c8;
    localparam logic [15:0] TMO_MAX = 16'hfde8;
    localparam logic [15:0] WD_TMO_RST = 16'h01f4;
    localparam logic [15:0] CONN_TMO_RST = 16'h0000;
    localparam logic [1:0] MODE_ALL_LOW = 2'h0;
    localparam logic [1:0] MODE_RESET = 2'h1;
    localparam logic [1:0] MODE_HOLD = 2'h2;
    localparam logic [15:0] CMD_FORCE = 16'h0001;
    localparam logic [15:0] CMD_ACK = 16'h0002;
    localparam logic [15:0] REASON_NONE = 16'h0000;
    localparam logic [15:0] REASON_USER = 16'h0009;
    localparam logic [15:0] REASON_WD = 16'h000c;
    localparam logic [15:0] REASON_CONN = 16'h000d;
    localparam logic [15:0] DRV_ABORT_CODE = 16'h00aa;
    localparam logic [15:0] TCP_PORT = 16'h01f6;
    localparam int ST_OK_BIT = 0;
    localparam int ST_FAIL_BIT = 1;
    localparam logic [4:0] DIAG_ERR_MASK = 5'h1f;
    // Function and exception codes
    localparam logic [7:0] FC_RD_HOLD = 8'h03;
    localparam logic [7:0] FC_RD_IN = 8'h04;
    localparam logic [7:0] FC_WR_ONE = 8'h06;
    localparam logic [7:0] FC_WR_MULTI = 8'h10;
    localparam logic [7:0] FC_RDWR = 8'h17;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;
    localparam logic [7:0] EXC_FAIL = 8'h04;
    // Carriers
    typedef struct packed {logic write; logic last; logic [7:0] fc; logic [15:0] addr; logic [15:0] wdata;} pdwd_req_t;
    typedef struct packed {logic valid; logic [2:0] conn; logic [7:0] exc; logic [15:0] rdata;} pdwd_resp_t;
    typedef struct packed {logic valid; logic [9:0] addr; logic [15:0] data;} pdwd_img_wr_t;
    typedef enum {WD_INIT, WD_ARMED, WD_FAILED, WD_OFF} pdwd_state_t;
endpackage

// [bench/pdwd_client.sv]
`timescale 1ns/1ps
module pdwd_client
    import pdwd_pkg::*;
(
    // Clock
    input wire logic core_clk_in,
    // Requests
    output logic [7:0] req_valid_out,
    output pdwd_pkg::pdwd_req_t req_out [8],
    // Grants and answers
    input wire logic [7:0] req_ready_in,
    input pdwd_pkg::pdwd_resp_t resp_in
);
    // Cleared by the bench to send a word that keeps the grant locked
    logic last_word;

    initial
    begin
        last_word = 1'b1;
        req_valid_out = 8'h00;
        for (int i = 0; i < 8; i++)
            req_out[i] = '0;
    end

    // Released word is inverted so a stale request never looks live
    task automatic xfer(input logic [2:0] c, input logic wr, input logic [7:0] fc, input logic [15:0] a,
                        input logic [15:0] d, output logic [7:0] exc, output logic [15:0] rd);
        pdwd_req_t r;
        int n;
        r = '{write: wr, last: last_word, fc: fc, addr: a, wdata: d};
        n = 0;
        req_valid_out[c] <= 1'b1;
        req_out[c] <= r;
        @(posedge core_clk_in);
        while (req_ready_in[c] !== 1'b1 && n < 50)
        begin
            @(posedge core_clk_in);
            n++;
        end
        req_valid_out[c] <= 1'b0;
        req_out[c] <= ~r;
        @(posedge core_clk_in);
        exc = (n < 50 && resp_in.valid === 1'b1) ? resp_in.exc : 8'hff;
        rd = resp_in.rdata;
    endtask
endmodule

// [bench/process_data_watchdog_bench.sv]
`timescale 1ns/1ps
module process_data_watchdog_bench;
    import pdwd_pkg::*;
    logic core_clk_in;
    logic rst_in;
    logic [7:0] rv;
    pdwd_req_t rq [8];
    logic [7:0] rr;
    pdwd_resp_t rs;
    logic ctmo;
    logic drv;
    logic abrt;
    logic [15:0] acode;
    logic [9:0] ia;
    logic [15:0] dst;
    logic nf;
    logic led;
    logic fa;
    logic [1:0] fm;
    logic [15:0] port;
    logic [15:0] ctm;
    pdwd_img_wr_t iw;
    pdwd_img_wr_t iw_seen;
    int n_fail = 0;
    int n_checks = 0;
    int n_apply = 0;

    initial
    begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end

    pdwd_watchdog #(.TICK(4)) pdwd_watchdog_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .req_valid_in(rv),
        .req_in(rq), .req_ready_out(rr), .resp_out(rs), .conn_timeout_in(ctmo), .conn_tmo_ms_out(ctm),
        .tcp_port_out(port), .drv_active_in(drv), .drv_abort_out(abrt), .drv_abort_code_out(acode),
        .img_rd_addr_out(ia), .img_rd_data_in({6'h00, ia} ^ 16'ha5a5), .img_wr_out(iw), .diag_status_in(dst),
        .diag_param1_in(16'h1234), .diag_param2_in(16'h5678), .net_fail_out(nf), .net_fail_led_out(led),
        .fault_apply_out(fa), .fault_mode_out(fm));

    pdwd_client pdwd_client_i (.core_clk_in(core_clk_in), .req_valid_out(rv), .req_out(rq),
        .req_ready_in(rr), .resp_in(rs));

    always @(posedge core_clk_in)
        if (fa === 1'b1)
            n_apply <= n_apply + 1;

    // Last image write that landed, so a refused write can be seen not to land
    always @(posedge core_clk_in)
        if (iw.valid === 1'b1)
            iw_seen <= iw;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [2:0] c, input logic [7:0] fc, input logic [15:0] a, input logic [15:0] ed);
        logic [7:0] e;
        logic [15:0] d;
        pdwd_client_i.xfer(c, 1'b0, fc, a, 16'h0000, e, d);
        check({8'h00, e}, 16'h0000);
        check(d, ed);
    endtask

    task automatic wrf(input logic [2:0] c, input logic [7:0] fc, input logic [15:0] a, input logic [15:0] d,
                       input logic [7:0] ee);
        logic [7:0] e;
        logic [15:0] x;
        pdwd_client_i.xfer(c, 1'b1, fc, a, d, e, x);
        check({8'h00, e}, {8'h00, ee});
    endtask

    task automatic wr(input logic [2:0] c, input logic [15:0] a, input logic [15:0] d, input logic [7:0] ee);
        wrf(c, FC_WR_MULTI, a, d, ee);
    endtask

    task automatic ms(input int n);
        repeat (n * 4) @(posedge core_clk_in);
    endtask

    task automatic do_reset();
        rst_in <= 1'b1;
        repeat (12) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
    endtask

    task automatic stop_test();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge core_clk_in);
        n_fail++;
        stop_test();
    end

    initial
    begin
        rst_in = 1'b1;
        ctmo = 1'b0;
        drv = 1'b0;
        dst = 16'h0000;
        do_reset();
        check({14'h0, fm}, {14'h0, MODE_RESET});
        rd(0, FC_RD_HOLD, A_WD_TMO, WD_TMO_RST);
        rd(1, FC_RD_IN, A_STATUS, 16'h0001);
        rd(2, FC_RD_HOLD, A_DI + 16'h0005, 16'ha5a0);
        rd(2, FC_RD_IN, A_DYN, 16'ha6a5);
        rd(2, FC_RD_IN, A_DYN + 16'h0001, 16'ha5a5);
        rd(2, FC_RD_HOLD, A_DYN + 16'h0006, 16'ha425);
        wr(2, A_DYN + 16'h0001, 16'h0000, EXC_ADDR);
        check(port, 16'h01f6);
        $display("reset test done");
        repeat (5)
        begin
            rd(0, FC_RD_HOLD, A_DO, 16'ha425);
            ms(120);
        end
        check({15'h0, nf}, 16'h0000);
        $display("unarmed test done");
        wr(0, A_WD_TMO, 16'h00c7, EXC_VALUE);
        wr(0, A_WD_TMO, 16'hfde9, EXC_VALUE);
        wr(0, A_WD_TMO, TMO_MAX, EXC_NONE);
        rd(0, FC_RD_HOLD, A_WD_TMO, TMO_MAX);
        wr(0, A_WD_TMO, TMO_MIN, EXC_NONE);
        rd(0, FC_RD_HOLD, A_WD_TMO, TMO_MIN);
        wr(0, A_CONN_TMO, 16'h00c7, EXC_VALUE);
        wr(0, A_CONN_TMO, 16'h03e8, EXC_NONE);
        rd(0, FC_RD_HOLD, A_CONN_TMO, 16'h03e8);
        check(ctm, 16'h03e8);
        for (int m = 0; m < 3; m++)
        begin
            wr(0, A_MODE, 16'(m), EXC_NONE);
            check({14'h0, fm}, 16'(m));
        end
        wr(0, A_MODE, 16'h0003, EXC_VALUE);
        $display("config test done");
        wrf(0, FC_WR_ONE, A_DO, 16'h0001, EXC_NONE);
        for (int k = 1; k < 8; k++)
        begin
            ms(150);
            wrf(3'(k), (k % 2 == 1) ? FC_RDWR : FC_WR_MULTI, A_AO, 16'(k), EXC_NONE);
        end
        pdwd_client_i.last_word = 1'b0;
        wr(1, A_DO, 16'h0010, EXC_NONE);
        pdwd_client_i.last_word = 1'b1;
        fork
            wr(2, A_AO, 16'h0011, EXC_NONE);
            begin
                repeat (3) @(posedge core_clk_in);
                check({8'h00, rr}, 16'h0000);
                wr(1, A_DO, 16'h0012, EXC_NONE);
            end
        join
        check({15'h0, nf}, 16'h0000);
        wrf(0, 8'h05, A_DO, 16'h0000, EXC_FUNC);
        wr(0, A_DI, 16'h0000, EXC_ADDR);
        wr(0, A_STATUS, 16'h0000, EXC_ADDR);
        wr(0, A_WD_TMO, 16'h0000, EXC_VALUE);
        wr(3, A_DO, 16'h0002, EXC_NONE);
        rd(0, FC_RD_HOLD, A_DO, 16'ha425);
        ms(188);
        check({15'h0, nf}, 16'h0000);
        ms(20);
        check({14'h0, nf, led}, 16'h0003);
        check(n_apply[15:0], 16'h0001);
        rd(0, FC_RD_HOLD, A_REASON, REASON_WD);
        rd(0, FC_RD_HOLD, A_STATUS, 16'h0003);
        wr(0, A_DO, 16'h0003, EXC_FAIL);
        ms(300);
        check({15'h0, nf}, 16'h0001);
        check(iw_seen.data, 16'h0002);
        check({6'h00, iw_seen.addr}, A_DO);
        wr(0, A_CMD, CMD_ACK, EXC_NONE);
        check({15'h0, nf}, 16'h0000);
        ms(190);
        check({15'h0, nf}, 16'h0000);
        ms(20);
        check({15'h0, nf}, 16'h0001);
        check(n_apply[15:0], 16'h0002);
        $display("expiry test done");
        wr(0, A_CMD, CMD_ACK, EXC_NONE);
        wr(5, A_CMD, CMD_FORCE, EXC_NONE);
        rd(5, FC_RD_HOLD, A_REASON, REASON_USER);
        wr(0, A_CMD, CMD_ACK, EXC_NONE);
        @(posedge core_clk_in);
        ctmo <= 1'b1;
        @(posedge core_clk_in);
        ctmo <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        check({15'h0, nf}, 16'h0001);
        rd(0, FC_RD_HOLD, A_REASON, REASON_CONN);
        wr(0, A_CMD, CMD_ACK, EXC_NONE);
        dst <= 16'h0004;
        rd(0, FC_RD_HOLD, A_STATUS, 16'h0000);
        rd(0, FC_RD_HOLD, A_DIAG_ST, 16'h0004);
        rd(0, FC_RD_HOLD, A_DIAG_P1, 16'h1234);
        rd(0, FC_RD_HOLD, A_DIAG_P2, 16'h5678);
        wr(0, A_DIAG_ST, 16'h0000, EXC_ADDR);
        $display("reason test done");
        drv <= 1'b1;
        check({15'h0, abrt}, 16'h0000);
        rd(0, FC_RD_HOLD, A_DI, 16'ha5a5);
        drv <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        check({15'h0, abrt}, 16'h0001);
        check(acode, DRV_ABORT_CODE);
        do_reset();
        check({15'h0, abrt}, 16'h0000);
        wr(0, A_WD_TMO, 16'h0000, EXC_NONE);
        wr(0, A_DO, 16'h0001, EXC_NONE);
        ms(600);
        check({15'h0, nf}, 16'h0000);
        $display("driver and disable test done");
        stop_test();
    end
endmodule
